// *** design/spw_wakeup.sv ***
// How it works
// - Wait window equals (ratio field plus one) listen windows, ratio 1..128.
// - Wake period is one listen window plus the wait window.
// - Listen window spans 0.48 ms to 20.88 ms.
// - A validated pattern during listening sets the pattern-found flag.
// - Reading flags clears flag and polling enable, data high, standby.
// - Four-bit length code L selects an L plus one bit pattern.
// - Sixteen-bit pattern in two bytes; bit 0 is newest received.
// - Each raw bit expands to two symbols: 0 gives 10, 1 gives 01.
// - Only pattern bits L down to 0 take part in the match.
// - Match is checked at every symbol, so any phase alignment triggers.
// - In host-controlled receive the data output follows demodulated symbols.
// - Data output stays high while listening and into a matchless wait.
// - After a match data goes low on wait entry and stays low through the wait.
// - Unread flag: listen again high, drop low at each wait entry.
// - Listen window is 0.48 ms plus 0.08 ms per field count.
// - Polling starts when enable is written one in standby with the crystal on.
`timescale 1ns/1ps
`default_nettype none
module spw_wakeup (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic pwrdn,
	// Serial register port
	input wire logic spi_csb_n,
	input wire logic spi_sclk,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	// Demodulated symbol stream
	input wire logic demod_valid,
	input wire logic demod_bit,
	output logic demod_ready,
	// Data pin and status
	output logic data_out,
	output logic receiver_on
);
	// ==========================================
	// Registers and state
	spw_pkg::spw_state_type state;
	spw_pkg::spw_state_type next_state;
	logic [15:0] pattern_word;
	logic [7:0] listen_time;
	logic [6:0] wait_listen_ratio;
	logic [3:0] pattern_length;
	logic xo_enable;
	logic polling_enable;
	logic host_listen_enable;
	logic pattern_found_flag;

	// ==========================================
	// Serial slave, mode 0, MSB first:
	// header = read bit + 7-bit address, then one data byte
	logic sclk_q;
	logic [4:0] bit_cnt;
	logic [6:0] shift_in;
	logic [6:0] addr;
	logic is_read;
	logic [7:0] out_shift;

	wire sclk_rise = ~spi_csb_n & spi_sclk & ~sclk_q;
	wire sclk_fall = ~spi_csb_n & ~spi_sclk & sclk_q;
	wire header_done = sclk_rise & (bit_cnt == spw_pkg::SPI_HEADER_LAST);
	wire [6:0] header_addr = {shift_in[5:0], sdio_in};
	wire header_read = shift_in[6];
	wire read_flags = header_done & header_read
		& (header_addr == spw_pkg::ADDR_INTERRUPT_FLAGS);
	wire wr_strobe = sclk_rise & ~is_read
		& (bit_cnt == spw_pkg::SPI_FRAME_LAST);
	wire [7:0] wdata = {shift_in, sdio_in};
	wire data_phase = (bit_cnt[4:3] == 2'b01);

	function automatic logic hit(input logic [6:0] a, input logic [6:0] b);
		hit = (a == b);
	endfunction : hit

	wire [7:0] power_state_value = {5'h00,
		host_listen_enable, polling_enable, xo_enable};

	function automatic logic [7:0] read_mux(input logic [6:0] a,
		input logic [15:0] pw, input logic [7:0] lt, input logic [6:0] wr,
		input logic [3:0] pl, input logic pf, input logic [7:0] ps);
		read_mux = 8'h00;
		if (hit(a, spw_pkg::ADDR_PATTERN_LOW)) read_mux = pw[7:0];
		if (hit(a, spw_pkg::ADDR_PATTERN_HIGH)) read_mux = pw[15:8];
		if (hit(a, spw_pkg::ADDR_INTERRUPT_FLAGS)) read_mux = {7'h00, pf};
		if (hit(a, spw_pkg::ADDR_POWER_STATE)) read_mux = ps;
		if (hit(a, spw_pkg::ADDR_LISTEN_TIME)) read_mux = lt;
		if (hit(a, spw_pkg::ADDR_WAKE_RATIO)) read_mux = {1'b0, wr};
		if (hit(a, spw_pkg::ADDR_PATTERN_LENGTH)) read_mux = {4'h0, pl};
	endfunction : read_mux

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			bit_cnt <= 5'h00;
			shift_in <= 7'h00;
			addr <= 7'h00;
			is_read <= 1'b0;
			out_shift <= 8'h00;
			sdio_out <= 1'b0;
			sdio_oe_n <= 1'b1;
		end else if (ce) begin
			sclk_q <= spi_sclk;
			if (spi_csb_n || pwrdn) begin
				bit_cnt <= 5'h00;
				sdio_oe_n <= 1'b1;
			end else if (sclk_rise) begin
				shift_in <= {shift_in[5:0], sdio_in};
				bit_cnt <= bit_cnt + 5'h01;
				if (header_done) begin
					addr <= header_addr;
					is_read <= header_read;
					out_shift <= read_mux(header_addr, pattern_word,
						listen_time, wait_listen_ratio, pattern_length,
						pattern_found_flag, power_state_value);
				end
			end else if (sclk_fall && is_read && data_phase) begin
				sdio_out <= out_shift[7];
				out_shift <= {out_shift[6:0], 1'b0};
				sdio_oe_n <= 1'b0;
			end
		end
	end

	// ==========================================
	// Register writes; configuration is locked outside standby
	wire cfg_open = (state == spw_pkg::SPW_STANDBY);
	wire ctrl_wr = wr_strobe & hit(addr, spw_pkg::ADDR_POWER_STATE);
	wire cfg_wr = wr_strobe & cfg_open;
	wire want_poll = wdata[spw_pkg::BIT_POLLING_ENABLE];
	wire want_host = wdata[spw_pkg::BIT_HOST_LISTEN_ENABLE];
	logic match_now;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pattern_word <= spw_pkg::RESET_PATTERN_WORD;
			listen_time <= spw_pkg::RESET_LISTEN_TIME;
			wait_listen_ratio <= spw_pkg::RESET_WAIT_RATIO;
			pattern_length <= spw_pkg::RESET_PATTERN_LENGTH;
			xo_enable <= 1'b0;
			polling_enable <= 1'b0;
			host_listen_enable <= 1'b0;
			pattern_found_flag <= 1'b0;
		end else if (ce && pwrdn) begin
			pattern_word <= spw_pkg::RESET_PATTERN_WORD;
			listen_time <= spw_pkg::RESET_LISTEN_TIME;
			wait_listen_ratio <= spw_pkg::RESET_WAIT_RATIO;
			pattern_length <= spw_pkg::RESET_PATTERN_LENGTH;
			xo_enable <= 1'b0;
			polling_enable <= 1'b0;
			host_listen_enable <= 1'b0;
			pattern_found_flag <= 1'b0;
		end else if (ce) begin
			if (cfg_wr && hit(addr, spw_pkg::ADDR_PATTERN_LOW))
				pattern_word[7:0] <= wdata;
			if (cfg_wr && hit(addr, spw_pkg::ADDR_PATTERN_HIGH))
				pattern_word[15:8] <= wdata;
			if (cfg_wr && hit(addr, spw_pkg::ADDR_LISTEN_TIME))
				listen_time <= wdata;
			if (cfg_wr && hit(addr, spw_pkg::ADDR_WAKE_RATIO))
				wait_listen_ratio <= wdata[6:0];
			if (cfg_wr && hit(addr, spw_pkg::ADDR_PATTERN_LENGTH))
				pattern_length <= wdata[3:0];
			if (ctrl_wr) begin
				xo_enable <= wdata[spw_pkg::BIT_XO_ENABLE];
				// Polling only starts from standby with the crystal on
				if (!want_poll || (cfg_open && !host_listen_enable))
					polling_enable <= want_poll;
				if (!want_host || !polling_enable)
					host_listen_enable <= want_host;
			end
			if (read_flags)
				polling_enable <= 1'b0;
			// A match in the clearing cycle survives the clear
			pattern_found_flag <= match_now
				| (pattern_found_flag & ~read_flags);
		end
	end

	// ==========================================
	// Wake timer: prescaler tick, listen and wait counters
	logic [11:0] prescale;
	logic [8:0] ticks_left;
	logic [7:0] windows_left;
	wire tick = (prescale == 12'(spw_pkg::TICK_CYCLES - 1));
	wire [8:0] listen_ticks = 9'(spw_pkg::LISTEN_MIN_TICKS)
		+ {1'b0, listen_time};
	wire window_done = tick & (ticks_left == 9'h001);
	wire polling = (state == spw_pkg::SPW_LISTEN)
		| (state == spw_pkg::SPW_WAIT);

	always_comb begin
		next_state = state;
		unique case (state)
			spw_pkg::SPW_STANDBY: begin
				if (polling_enable && xo_enable)
					next_state = spw_pkg::SPW_WAIT;
				else if (host_listen_enable && xo_enable)
					next_state = spw_pkg::SPW_HOST;
			end
			spw_pkg::SPW_LISTEN: begin
				if (!polling_enable || read_flags)
					next_state = spw_pkg::SPW_STANDBY;
				else if (window_done)
					next_state = spw_pkg::SPW_WAIT;
			end
			spw_pkg::SPW_WAIT: begin
				if (!polling_enable || read_flags)
					next_state = spw_pkg::SPW_STANDBY;
				else if (window_done && windows_left == 8'h00)
					next_state = spw_pkg::SPW_LISTEN;
			end
			spw_pkg::SPW_HOST: begin
				if (!host_listen_enable || !xo_enable)
					next_state = spw_pkg::SPW_STANDBY;
			end
		endcase
	end

	wire changing = (next_state != state);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= spw_pkg::SPW_STANDBY;
			prescale <= 12'h000;
			ticks_left <= 9'h000;
			windows_left <= 8'h00;
		end else if (ce) begin
			state <= pwrdn ? spw_pkg::SPW_STANDBY : next_state;
			if (changing || !polling || tick)
				prescale <= 12'h000;
			else
				prescale <= prescale + 12'h001;
			if (changing) begin
				ticks_left <= listen_ticks;
				windows_left <= {1'b0, wait_listen_ratio};
			end else if (window_done) begin
				ticks_left <= listen_ticks;
				windows_left <= windows_left - 8'h01;
			end else if (tick) begin
				ticks_left <= ticks_left - 9'h001;
			end
		end
	end

	// ==========================================
	// Symbol buffer between demodulator and matcher
	wire rx_active = (state == spw_pkg::SPW_LISTEN)
		| (state == spw_pkg::SPW_HOST);
	wire sym_valid;
	wire [spw_pkg::SYMBOL_WIDTH-1:0] sym_data;
	wire sym_pop = sym_valid & rx_active;

	spw_fifo #(
		.WIDTH(spw_pkg::SYMBOL_WIDTH),
		.DEPTH(spw_pkg::FIFO_DEPTH)
	) symbol_fifo (
		.clock(clock),
		.rst(rst),
		.ce(ce),
		.in_valid(demod_valid),
		.in_data(demod_bit),
		.in_ready(demod_ready),
		.out_valid(sym_valid),
		.out_data(sym_data),
		.out_ready(rx_active)
	);

	// ==========================================
	// Manchester matcher
	logic [31:0] symbols;
	logic [31:0] expected;
	logic [31:0] care;
	wire [31:0] next_symbols = {symbols[30:0], sym_data[0]};

	generate
		for (genvar i = 0; i < 16; i++) begin : g_expand
			// Raw 0 gives symbols 1 then 0, raw 1 gives 0 then 1
			assign expected[2*i] = pattern_word[i];
			assign expected[2*i+1] = ~pattern_word[i];
			assign care[2*i] = (4'(i) <= pattern_length);
			assign care[2*i+1] = (4'(i) <= pattern_length);
		end
	endgenerate

	// Checked on every symbol, so the pattern may start at any phase
	assign match_now = sym_pop & (state == spw_pkg::SPW_LISTEN)
		& (((next_symbols ^ expected) & care) == 32'h0);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			symbols <= 32'h0;
		end else if (ce) begin
			// Flushed on listen entry so old symbols cannot match
			if (changing && next_state == spw_pkg::SPW_LISTEN)
				symbols <= 32'h0;
			else if (sym_pop)
				symbols <= next_symbols;
		end
	end

	// ==========================================
	// Data pin and status
	wire next_flag = match_now | (pattern_found_flag & ~read_flags);
	wire low_in_wait = (next_state == spw_pkg::SPW_WAIT) & next_flag;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			data_out <= 1'b1;
			receiver_on <= 1'b0;
		end else if (ce) begin
			receiver_on <= ~pwrdn & (next_state == spw_pkg::SPW_LISTEN
				| next_state == spw_pkg::SPW_HOST);
			if (pwrdn)
				data_out <= 1'b1;
			else if (state == spw_pkg::SPW_HOST && next_state == state)
				data_out <= sym_pop ? sym_data[0] : data_out;
			else if (low_in_wait)
				data_out <= 1'b0;
			else
				data_out <= 1'b1;
		end
	end
endmodule : spw_wakeup
`default_nettype wire

// *** design/spw_pkg.sv ***
`default_nettype none
package spw_pkg;
	// ==========================================
	// Register offsets (7-bit serial addresses)
	localparam logic [6:0] ADDR_PATTERN_LOW = 7'h0D;
	localparam logic [6:0] ADDR_PATTERN_HIGH = 7'h0E;
	localparam logic [6:0] ADDR_INTERRUPT_FLAGS = 7'h13;
	localparam logic [6:0] ADDR_POWER_STATE = 7'h14;
	localparam logic [6:0] ADDR_LISTEN_TIME = 7'h17;
	localparam logic [6:0] ADDR_WAKE_RATIO = 7'h18;
	localparam logic [6:0] ADDR_PATTERN_LENGTH = 7'h19;

	// ==========================================
	// Field positions
	localparam int BIT_PATTERN_FOUND = 0;
	localparam int BIT_XO_ENABLE = 0;
	localparam int BIT_POLLING_ENABLE = 1;
	localparam int BIT_HOST_LISTEN_ENABLE = 2;

	// ==========================================
	// Reset values
	localparam logic [15:0] RESET_PATTERN_WORD = 16'h0000;
	localparam logic [7:0] RESET_LISTEN_TIME = 8'h00;
	localparam logic [6:0] RESET_WAIT_RATIO = 7'h00;
	localparam logic [3:0] RESET_PATTERN_LENGTH = 4'hF;

	// ==========================================
	// Timing
	localparam int CLOCK_PERIOD_NS = 20;
	localparam int LISTEN_STEP_NS = 80000;
	localparam int LISTEN_MIN_NS = 480000;
	localparam int TICK_CYCLES = (LISTEN_STEP_NS + CLOCK_PERIOD_NS - 1)
		/ CLOCK_PERIOD_NS;
	localparam int LISTEN_MIN_TICKS = LISTEN_MIN_NS / LISTEN_STEP_NS;

	// ==========================================
	// Serial frame layout
	localparam logic [4:0] SPI_HEADER_LAST = 5'h07;
	localparam logic [4:0] SPI_FRAME_LAST = 5'h0F;

	// ==========================================
	// Data path
	localparam int SYMBOL_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;

	typedef enum logic [1:0] {
		SPW_STANDBY = 2'b00,
		SPW_LISTEN = 2'b01,
		SPW_WAIT = 2'b10,
		SPW_HOST = 2'b11
	} spw_state_type;
endpackage : spw_pkg
`default_nettype wire

// *** design/spw_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module spw_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// Filling side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Draining side
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	// ==========================================
	// Storage; DEPTH must be a power of two so pointers wrap freely
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;

	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	wire [AW:0] next_count = count + {{AW{1'b0}}, push}
		- {{AW{1'b0}}, pop};

	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b1;
		end else if (ce) begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count <= next_count;
			// Registered so the source sees a clean flop
			in_ready <= (next_count != FULL_COUNT);
		end
	end
endmodule : spw_fifo
`default_nettype wire

// *** testbench/spw_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module spw_monitor (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic pwrdn,
	// Serial port
	input wire logic spi_csb_n,
	input wire logic spi_sclk,
	input wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n,
	// Stream and pin
	input wire logic demod_valid,
	input wire logic demod_bit,
	input wire logic demod_ready,
	input wire logic data_out,
	input wire logic receiver_on
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// ==========================================
	// Sequences
	sequence s_csb_idle;
		spi_csb_n ##1 spi_csb_n;
	endsequence
	sequence s_wait_low;
		!data_out && !receiver_on && spi_csb_n && !pwrdn;
	endsequence
	// ==========================================
	// Properties
	a_fall_at_wait: assert property (
		$fell(data_out) |-> receiver_on || $fell(receiver_on))
		else $error("data pin fell away from wait entry");
	a_wait_hold_low: assert property (
		s_wait_low |=> !data_out || receiver_on)
		else $error("data pin left low level during wait");
	a_listen_entry_high: assert property (
		$rose(receiver_on) |-> data_out)
		else $error("data pin low on listen entry");
	a_rise_needs_read: assert property (
		$rose(data_out) && !receiver_on && !$fell(receiver_on)
		|-> !$past(spi_csb_n) || $past(pwrdn))
		else $error("data pin rose without status read");
	a_pwrdn_quiet: assert property (
		ce && pwrdn |=> data_out && !receiver_on && sdio_oe_n)
		else $error("power down left outputs active");
	a_sdio_release: assert property (
		s_csb_idle |-> sdio_oe_n)
		else $error("serial data driven while deselected");
	a_ready_fall_push: assert property (
		$fell(demod_ready) |-> $past(demod_valid) || $past(demod_valid, 2))
		else $error("ready fell without a push");
	a_ready_rise_drain: assert property (
		$rose(demod_ready) |-> $past(receiver_on))
		else $error("symbols drained while receiver off");
endmodule : spw_monitor
bind spw_wakeup spw_monitor mon (.clock(clock), .rst(rst), .ce(ce),
	.pwrdn(pwrdn), .spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk),
	.sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
	.demod_valid(demod_valid), .demod_bit(demod_bit),
	.demod_ready(demod_ready), .data_out(data_out),
	.receiver_on(receiver_on));
`default_nettype wire

// *** testbench/spw_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spw_host_model (
	// Clock
	input wire logic clock,
	// Serial port
	output logic spi_csb_n,
	output logic spi_sclk,
	output logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_n
);
	logic mosi;
	// Shared line: the device wins while it drives
	assign sdio_in = sdio_oe_n ? mosi : sdio_out;
	initial begin
		spi_csb_n = 1'b1;
		spi_sclk = 1'b0;
		mosi = 1'b0;
	end
	task automatic xfer(input logic rw, input logic [6:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] f;
		f = {rw, a, wd};
		rd = 8'h00;
		@(posedge clock);
		spi_csb_n <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clock);
			mosi <= f[15-i];
			repeat (2) @(posedge clock);
			if (i > 7) rd = {rd[6:0], sdio_in};
			spi_sclk <= 1'b1;
			repeat (2) @(posedge clock);
			spi_sclk <= 1'b0;
		end
		repeat (3) @(posedge clock);
		spi_csb_n <= 1'b1;
		// Released line must not look like held data
		mosi <= ~mosi;
		repeat (3) @(posedge clock);
	endtask : xfer
endmodule : spw_host_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic pwrdn, demod_valid, demod_bit;
	wire logic spi_csb_n, spi_sclk, sdio_in, sdio_out, sdio_oe_n;
	wire logic demod_ready, data_out, receiver_on;
	int failures = 0;
	int cmp_count = 0;
	logic [31:0] seed = 32'h0001640A;
	logic [7:0] rd;
	logic [15:0] w;
	logic [31:0] m;
	time t0;
	int n;
	spw_wakeup dut (.clock(clock), .rst(rst), .ce(1'b1), .pwrdn(pwrdn),
		.spi_csb_n(spi_csb_n), .spi_sclk(spi_sclk), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n),
		.demod_valid(demod_valid), .demod_bit(demod_bit),
		.demod_ready(demod_ready), .data_out(data_out),
		.receiver_on(receiver_on));
	spw_host_model host (.clock(clock), .spi_csb_n(spi_csb_n),
		.spi_sclk(spi_sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
		.sdio_oe_n(sdio_oe_n));
	always #10 clock = ~clock;
	// ==========================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic int listen_cyc(input int lt);
		return (spw_pkg::LISTEN_MIN_TICKS + lt) * spw_pkg::TICK_CYCLES;
	endfunction : listen_cyc
	function automatic logic [31:0] manch(input logic [15:0] pw);
		logic [31:0] s;
		for (int i = 0; i < 16; i++) s[2*i+:2] = {~pw[i], pw[i]};
		return s;
	endfunction : manch
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host.xfer(1'b0, a, d, rd);
	endtask : wr
	task automatic rdc(input string what, input logic [6:0] a,
		input logic [7:0] e);
		host.xfer(1'b1, a, 8'h00, rd);
		check(what, 16'(rd), 16'(e));
	endtask : rdc
	task automatic push(input logic b);
		demod_valid <= 1'b1;
		demod_bit <= b;
		@(posedge clock);
		while (demod_ready !== 1'b1) @(posedge clock);
	endtask : push
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		repeat (95000) @(posedge clock);
		failures++;
		$display("watchdog expired");
		end_sim();
	end
	// ==========================================
	// Tests
	initial begin
		pwrdn = 1'b0;
		demod_valid = 1'b0;
		demod_bit = 1'b0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		check("data_out", 16'(data_out), 16'h0001);
		rdc("length reset", spw_pkg::ADDR_PATTERN_LENGTH, 8'h0F);
		for (int c = 0; c < 16; c++) begin
			wr(spw_pkg::ADDR_PATTERN_LENGTH, 8'(c));
			rdc("length", spw_pkg::ADDR_PATTERN_LENGTH, 8'(c));
		end
		rdc("unmapped", 7'h7F, 8'h00);
		seed = xs(seed);
		wr(spw_pkg::ADDR_PATTERN_LOW, seed[7:0]);
		wr(spw_pkg::ADDR_PATTERN_HIGH, seed[15:8]);
		rdc("word low", spw_pkg::ADDR_PATTERN_LOW, seed[7:0]);
		rdc("word high", spw_pkg::ADDR_PATTERN_HIGH, seed[15:8]);
		seed = xs(seed);
		wr(spw_pkg::ADDR_LISTEN_TIME, seed[7:0]);
		wr(spw_pkg::ADDR_WAKE_RATIO, seed[15:8]);
		rdc("listen time", spw_pkg::ADDR_LISTEN_TIME, seed[7:0]);
		rdc("ratio", spw_pkg::ADDR_WAKE_RATIO, {1'b0, seed[14:8]});
		$display("register test done");
		// Fill in standby, then drain in host receive
		@(posedge clock);
		for (int i = 0; i < 16; i++) push(i == 15 ? 1'b0 : 1'b1);
		demod_valid <= 1'b0;
		repeat (2) @(negedge clock);
		check("ready full", 16'(demod_ready), 16'h0000);
		wr(spw_pkg::ADDR_POWER_STATE, 8'h05);
		wr(spw_pkg::ADDR_PATTERN_LENGTH, 8'h03);
		check("rx on", 16'(receiver_on), 16'h0001);
		check("data follows", 16'(data_out), 16'h0000);
		check("ready drained", 16'(demod_ready), 16'h0001);
		wr(spw_pkg::ADDR_POWER_STATE, 8'h01);
		rdc("locked length", spw_pkg::ADDR_PATTERN_LENGTH, 8'h0F);
		$display("buffer test done");
		// Self-polling with a two-bit pattern
		seed = xs(seed);
		w = {seed[15:2], 2'b10};
		wr(spw_pkg::ADDR_PATTERN_LOW, w[7:0]);
		wr(spw_pkg::ADDR_PATTERN_HIGH, w[15:8]);
		wr(spw_pkg::ADDR_PATTERN_LENGTH, 8'h01);
		wr(spw_pkg::ADDR_LISTEN_TIME, 8'h00);
		wr(spw_pkg::ADDR_WAKE_RATIO, 8'h01);
		wr(spw_pkg::ADDR_POWER_STATE, 8'h03);
		n = 0;
		while (receiver_on !== 1'b1) begin
			@(negedge clock);
			n++;
		end
		t0 = $time;
		check("wait", 16'(n >= 2 * listen_cyc(0) - 12
			&& n <= 2 * listen_cyc(0) + 2), 16'h0001);
		check("listen high", 16'(data_out), 16'h0001);
		@(posedge clock);
		seed = xs(seed);
		for (int i = 0; i < 3; i++) push(seed[i]);
		m = manch(w);
		for (int i = 3; i >= 0; i--) push(m[i]);
		demod_valid <= 1'b0;
		while (receiver_on !== 1'b0) @(negedge clock);
		n = int'(($time - t0) / 20);
		check("listen", 16'(n >= listen_cyc(0) - 1
			&& n <= listen_cyc(0) + 1), 16'h0001);
		check("wake low", 16'(data_out), 16'h0000);
		repeat (50) @(negedge clock);
		check("held low", 16'(data_out), 16'h0000);
		rdc("flags", spw_pkg::ADDR_INTERRUPT_FLAGS, 8'h01);
		check("released", 16'(data_out), 16'h0001);
		rdc("polling off", spw_pkg::ADDR_POWER_STATE, 8'h01);
		rdc("flags clear", spw_pkg::ADDR_INTERRUPT_FLAGS, 8'h00);
		wr(spw_pkg::ADDR_POWER_STATE, 8'h05);
		@(negedge clock);
		check("host rx", 16'(receiver_on), 16'h0001);
		$display("polling test done");
		@(posedge clock);
		pwrdn <= 1'b1;
		repeat (2) @(posedge clock);
		pwrdn <= 1'b0;
		@(negedge clock);
		check("pd rx", 16'(receiver_on), 16'h0000);
		rdc("pd length", spw_pkg::ADDR_PATTERN_LENGTH, 8'h0F);
		$display("power down test done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
